// ==== core/serial_port_pkg.sv ====
// constants shared by the serial port status and buffer block
package serial_port_pkg;

  // ===========================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // ===========================================
  // register indices, byte address is four times the index
  localparam logic [5:0] CTRL_A_IDX = 6'h1A;
  localparam logic [5:0] CTRL_B_IDX = 6'h1B;
  localparam logic [5:0] BAUD_IDX = 6'h1C;
  localparam logic [5:0] STATUS_IDX = 6'h1D;
  localparam logic [5:0] DATA_IDX = 6'h1E;
  localparam logic [5:0] POWER_IDX = 6'h1F;

  // ===========================================
  // status field positions
  localparam int ST_PARITY_ERR = 7;
  localparam int ST_FRAMING_ERR = 6;
  localparam int ST_OVERRUN_ERR = 5;
  localparam int ST_UNUSED = 4;
  localparam int ST_RX_BUSY = 3;
  localparam int ST_RX_FULL = 2;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_TX_FULL = 0;

  // ===========================================
  // control a field positions
  localparam int CA_TX_EN = 7;
  localparam int CA_RX_EN = 6;
  localparam int CA_TX_STOP2 = 5;
  localparam int CA_PARITY_EVEN = 4;
  localparam int CA_PARITY_ADD = 3;
  localparam int CA_IR_SEL = 2;
  localparam int CA_BASE_SEL = 1;

  // ===========================================
  // control b field positions
  localparam int CB_SAMPLE_LO = 3;
  localparam int CB_SAMPLE_W = 3;
  localparam int CB_NOISE_LO = 1;
  localparam int CB_NOISE_W = 2;
  localparam int CB_RX_STOP2 = 0;

  // ===========================================
  // power register field position
  localparam int PW_CLOCK_GATE = 0;

  // ===========================================
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] RX_HOLD_RST = 8'h00;
  localparam logic [7:0] TX_HOLD_RST = 8'h00;
  localparam logic GATE_RST = 1'b0;

endpackage

// ==== core/sticky_flag.sv ====
// one status flag, set has priority over clear
module sticky_flag
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);

  // ===========================================
  // flag storage
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      flag <= 1'b0;
    else if (set_pulse)
      flag <= 1'b1;
    else if (clear_pulse)
      flag <= 1'b0;
  end

endmodule

// ==== core/guarded_field.sv ====
// control field that takes a write only while unlocked
module guarded_field
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic write_strobe,
  input wire logic unlocked,
  input wire logic [WIDTH-1:0] write_value,
  output logic [WIDTH-1:0] value
);

  // ===========================================
  // locked writes leave the old value
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      value <= RESET_VALUE;
    else if (write_strobe && unlocked)
      value <= write_value;
  end

endmodule

// ==== core/serial_status_block.sv ====
// serial port status, data buffers, clock gate and write guard
//
// Decided for this implementation: the APB slave port.
module serial_status_block
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [serial_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [serial_port_pkg::DATA_W-1:0] pwdata,
  output logic [serial_port_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_mode,
  input wire logic idle_lowpower_mode,
  input wire logic sleep_lowpower_mode,
  input wire logic engine_rx_busy,
  input wire logic engine_tx_busy,
  input wire logic rx_byte_valid,
  input wire logic [serial_port_pkg::BYTE_W-1:0] rx_byte,
  input wire logic parity_error_pulse,
  input wire logic framing_error_pulse,
  input wire logic tx_done_irq,
  output logic port_clock_on,
  output logic port_halt,
  output logic tx_enable,
  output logic rx_enable,
  output logic tx_stop2,
  output logic parity_even,
  output logic parity_add,
  output logic ir_output_sel,
  output logic base_clock_sel,
  output logic [serial_port_pkg::CB_SAMPLE_W-1:0] sample_count_sel,
  output logic [serial_port_pkg::CB_NOISE_W-1:0] noise_time_sel,
  output logic rx_stop2,
  output logic [serial_port_pkg::BYTE_W-1:0] baud_divisor,
  output logic [serial_port_pkg::BYTE_W-1:0] tx_byte,
  output logic tx_full_flag
);

  // ===========================================
  // state
  logic serial_clock_gate_en_reg;
  logic tx_enable_reg;
  logic rx_enable_reg;
  logic rx_busy_reg;
  logic tx_busy_reg;
  logic lowpower_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [serial_port_pkg::DATA_W-1:0] prdata_reg;
  logic [7:0] baud_reg;
  logic [7:0] serial_rx_holding_reg;
  logic [7:0] serial_tx_holding_reg;
  logic parity_error_flag;
  logic framing_error_flag;
  logic overrun_error_flag;
  logic rx_full_flag;
  logic tx_full_int;
  logic tx_stop2_val;
  logic parity_even_val;
  logic parity_add_val;
  logic ir_sel_val;
  logic base_sel_val;
  logic [serial_port_pkg::CB_SAMPLE_W-1:0] sample_val;
  logic [serial_port_pkg::CB_NOISE_W-1:0] noise_val;
  logic rx_stop2_val;

  // ===========================================
  // address decode
  wire [5:0] reg_index = paddr[7:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_ctrl_a = aligned && (reg_index == serial_port_pkg::CTRL_A_IDX);
  wire hit_ctrl_b = aligned && (reg_index == serial_port_pkg::CTRL_B_IDX);
  wire hit_baud = aligned && (reg_index == serial_port_pkg::BAUD_IDX);
  wire hit_status = aligned && (reg_index == serial_port_pkg::STATUS_IDX);
  wire hit_data = aligned && (reg_index == serial_port_pkg::DATA_IDX);
  wire hit_power = aligned && (reg_index == serial_port_pkg::POWER_IDX);
  wire hit_any = hit_ctrl_a || hit_ctrl_b || hit_baud || hit_status
    || hit_data || hit_power;

  // ===========================================
  // bus phases
  wire setup_phase = psel && !penable;
  wire access_done = psel && penable && pready_reg;
  wire wr_done = access_done && pwrite && hit_any;
  wire rd_done = access_done && !pwrite && hit_any;
  wire [7:0] wbyte = pwdata[7:0];

  // ===========================================
  // clock gate and low-power mode
  wire lowpower_now = stop_mode || idle_lowpower_mode
    || sleep_lowpower_mode;
  wire lowpower_entry = lowpower_now && !lowpower_reg;
  wire port_live = serial_clock_gate_en_reg && !lowpower_now;
  wire port_wr = wr_done && serial_clock_gate_en_reg;

  // ===========================================
  // write strobes
  wire wr_ctrl_a = port_wr && hit_ctrl_a;
  wire wr_ctrl_b = port_wr && hit_ctrl_b;
  wire wr_baud = port_wr && hit_baud;
  wire wr_tx_hold = port_wr && hit_data;
  wire wr_power = wr_done && hit_power;
  wire rd_rx_hold = rd_done && hit_data;
  wire rd_status = rd_done && hit_status;

  // ===========================================
  // write guard conditions
  wire tx_idle = !tx_enable_reg && !tx_busy_reg;
  wire rx_idle = !rx_enable_reg && !rx_busy_reg;
  wire tx_unlock = tx_idle;
  wire all_unlock = tx_idle && rx_idle;
  wire rx_unlock = rx_idle;

  // ===========================================
  // receive and transmit events
  wire rx_take = rx_byte_valid && port_live;
  wire rx_store = rx_take && !rx_full_flag;
  wire rx_overrun = rx_take && rx_full_flag;
  wire tx_release = tx_done_irq && port_live;
  wire parity_err_set = parity_error_pulse && port_live;
  wire framing_err_set = framing_error_pulse && port_live;

  // ===========================================
  // status read clears only the errors that were reported
  wire parity_err_clr = (rd_status
    && prdata_reg[serial_port_pkg::ST_PARITY_ERR]) || lowpower_entry;
  wire framing_err_clr = (rd_status
    && prdata_reg[serial_port_pkg::ST_FRAMING_ERR]) || lowpower_entry;
  wire overrun_err_clr = (rd_status
    && prdata_reg[serial_port_pkg::ST_OVERRUN_ERR]) || lowpower_entry;
  wire rxf_clr = rd_rx_hold || lowpower_entry;
  wire txf_clr = tx_release || lowpower_entry;

  // ===========================================
  // status word
  wire [7:0] status_word = {parity_error_flag, framing_error_flag,
    overrun_error_flag, 1'b0, rx_busy_reg, rx_full_flag, tx_busy_reg,
    tx_full_int};

  wire [7:0] ctrl_a_word = {tx_enable_reg, rx_enable_reg, tx_stop2_val,
    parity_even_val, parity_add_val, ir_sel_val, base_sel_val, 1'b0};

  wire [7:0] ctrl_b_word = {2'b00, sample_val, noise_val, rx_stop2_val};

  wire [7:0] power_word = {7'h00, serial_clock_gate_en_reg};

  // ===========================================
  // read data select
  wire [7:0] read_byte = hit_ctrl_a ? ctrl_a_word
    : hit_ctrl_b ? ctrl_b_word
    : hit_baud ? baud_reg
    : hit_status ? status_word
    : hit_data ? serial_rx_holding_reg
    : hit_power ? power_word
    : 8'h00;

  wire [serial_port_pkg::DATA_W-1:0] prdata_next = setup_phase
    ? {24'h000000, read_byte} : prdata_reg;

  // ===========================================
  // error and buffer flags
  sticky_flag parity_err_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_pulse(parity_err_set && !lowpower_entry),
    .clear_pulse(parity_err_clr),
    .flag(parity_error_flag)
  );

  sticky_flag framing_err_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_pulse(framing_err_set && !lowpower_entry),
    .clear_pulse(framing_err_clr),
    .flag(framing_error_flag)
  );

  sticky_flag overrun_err_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_pulse(rx_overrun && !lowpower_entry),
    .clear_pulse(overrun_err_clr),
    .flag(overrun_error_flag)
  );

  sticky_flag rx_full_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_pulse(rx_store && !lowpower_entry),
    .clear_pulse(rxf_clr),
    .flag(rx_full_flag)
  );

  sticky_flag tx_full_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_pulse(wr_tx_hold && !lowpower_now),
    .clear_pulse(txf_clr),
    .flag(tx_full_int)
  );

  // ===========================================
  // protected control fields
  guarded_field #(.WIDTH(1), .RESET_VALUE(1'b0)) tx_stop2_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_strobe(wr_ctrl_a),
    .unlocked(tx_unlock),
    .write_value(wbyte[serial_port_pkg::CA_TX_STOP2]),
    .value(tx_stop2_val)
  );

  guarded_field #(.WIDTH(1), .RESET_VALUE(1'b0)) ir_sel_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_strobe(wr_ctrl_a),
    .unlocked(tx_unlock),
    .write_value(wbyte[serial_port_pkg::CA_IR_SEL]),
    .value(ir_sel_val)
  );

  guarded_field #(.WIDTH(3), .RESET_VALUE(3'h0)) common_a_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_strobe(wr_ctrl_a),
    .unlocked(all_unlock),
    .write_value({wbyte[serial_port_pkg::CA_PARITY_EVEN],
      wbyte[serial_port_pkg::CA_PARITY_ADD],
      wbyte[serial_port_pkg::CA_BASE_SEL]}),
    .value({parity_even_val, parity_add_val, base_sel_val})
  );

  guarded_field #(.WIDTH(serial_port_pkg::CB_SAMPLE_W),
    .RESET_VALUE(3'h0)) sample_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_strobe(wr_ctrl_b),
    .unlocked(all_unlock),
    .write_value(wbyte[serial_port_pkg::CB_SAMPLE_LO
      +: serial_port_pkg::CB_SAMPLE_W]),
    .value(sample_val)
  );

  guarded_field #(.WIDTH(3), .RESET_VALUE(3'h0)) rx_fields_i
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .write_strobe(wr_ctrl_b),
    .unlocked(rx_unlock),
    .write_value({wbyte[serial_port_pkg::CB_NOISE_LO
      +: serial_port_pkg::CB_NOISE_W],
      wbyte[serial_port_pkg::CB_RX_STOP2]}),
    .value({noise_val, rx_stop2_val})
  );

  // ===========================================
  // enables, cleared on low-power entry
  wire tx_enable_next = lowpower_now ? 1'b0
    : wr_ctrl_a ? wbyte[serial_port_pkg::CA_TX_EN] : tx_enable_reg;
  wire rx_enable_next = lowpower_now ? 1'b0
    : wr_ctrl_a ? wbyte[serial_port_pkg::CA_RX_EN] : rx_enable_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tx_enable_reg <= serial_port_pkg::CTRL_A_RST[serial_port_pkg::CA_TX_EN];
      rx_enable_reg <= serial_port_pkg::CTRL_A_RST[serial_port_pkg::CA_RX_EN];
    end
    else
    begin
      tx_enable_reg <= tx_enable_next;
      rx_enable_reg <= rx_enable_next;
    end
  end

  // ===========================================
  // busy flags follow the engines while the port runs
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_busy_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
    end
    else
    begin
      rx_busy_reg <= engine_rx_busy && port_live;
      tx_busy_reg <= engine_tx_busy && port_live;
    end
  end

  // ===========================================
  // clock gate, baud and low-power tracking
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      serial_clock_gate_en_reg <= serial_port_pkg::GATE_RST;
      baud_reg <= serial_port_pkg::BAUD_RST;
      lowpower_reg <= 1'b0;
    end
    else
    begin
      if (wr_power)
        serial_clock_gate_en_reg <= wbyte[serial_port_pkg::PW_CLOCK_GATE];
      if (wr_baud)
        baud_reg <= wbyte;
      lowpower_reg <= lowpower_now;
    end
  end

  // ===========================================
  // data buffers, cleared to zero on low-power entry
  wire [7:0] rx_hold_next = lowpower_entry ? serial_port_pkg::RX_HOLD_RST
    : rx_store ? rx_byte : serial_rx_holding_reg;
  wire [7:0] tx_hold_next = lowpower_entry ? serial_port_pkg::TX_HOLD_RST
    : (wr_tx_hold && !lowpower_now) ? wbyte
    : serial_tx_holding_reg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      serial_rx_holding_reg <= serial_port_pkg::RX_HOLD_RST;
      serial_tx_holding_reg <= serial_port_pkg::TX_HOLD_RST;
    end
    else
    begin
      serial_rx_holding_reg <= rx_hold_next;
      serial_tx_holding_reg <= tx_hold_next;
    end
  end

  // ===========================================
  // bus answer, one access cycle, no wait states
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end
    else
    begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !hit_any;
      prdata_reg <= prdata_next;
    end
  end

  // ===========================================
  // output drive
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      port_clock_on <= 1'b0;
      port_halt <= 1'b1;
    end
    else
    begin
      port_clock_on <= serial_clock_gate_en_reg;
      port_halt <= !port_live;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_enable = tx_enable_reg;
  assign rx_enable = rx_enable_reg;
  assign tx_stop2 = tx_stop2_val;
  assign parity_even = parity_even_val;
  assign parity_add = parity_add_val;
  assign ir_output_sel = ir_sel_val;
  assign base_clock_sel = base_sel_val;
  assign sample_count_sel = sample_val;
  assign noise_time_sel = noise_val;
  assign rx_stop2 = rx_stop2_val;
  assign baud_divisor = baud_reg;
  assign tx_byte = serial_tx_holding_reg;
  assign tx_full_flag = tx_full_int;

endmodule

// ==== tb/serial_status_chk.sv ====
// concurrent checks on the serial status block ports
module serial_status_chk
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [serial_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [serial_port_pkg::DATA_W-1:0] pwdata,
  input wire logic [serial_port_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic stop_mode,
  input wire logic idle_lowpower_mode,
  input wire logic sleep_lowpower_mode,
  input wire logic tx_done_irq,
  input wire logic port_clock_on,
  input wire logic port_halt,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_stop2,
  input wire logic parity_even,
  input wire logic parity_add,
  input wire logic ir_output_sel,
  input wire logic base_clock_sel,
  input wire logic [serial_port_pkg::CB_SAMPLE_W-1:0] sample_count_sel,
  input wire logic [serial_port_pkg::CB_NOISE_W-1:0] noise_time_sel,
  input wire logic rx_stop2,
  input wire logic [serial_port_pkg::BYTE_W-1:0] tx_byte,
  input wire logic tx_full_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // decode
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable && pready;
  wire lp = stop_mode || idle_lowpower_mode || sleep_lowpower_mode;
  wire wr_d = acc && pwrite && paddr == 8'h78;
  wire wr_p = acc && pwrite && paddr == 8'h7C;
  wire rd_s = acc && !pwrite && paddr == 8'h74;
  wire [7:0] wbyte = pwdata[7:0];
  wire [10:0] cfg = {tx_stop2, parity_even, parity_add, ir_output_sel,
    base_clock_sel, sample_count_sel, noise_time_sel, rx_stop2};
  // ==========================================
  // properties
  property p_tx_load;
    wr_d && !port_halt && !lp |=> tx_full_flag && tx_byte == $past(wbyte);
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("tx buffer load wrong");
  property p_tx_done;
    tx_done_irq && !wr_d && !port_halt && !lp |=> !tx_full_flag;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("tx full not cleared");
  property p_lp_ctrl;
    lp ##1 lp |-> !tx_enable && !rx_enable && $stable(cfg);
  endproperty
  a_lp_ctrl: assert property (p_lp_ctrl)
    else $error("low power control bits wrong");
  property p_lp_flag;
    $rose(lp) |=> !tx_full_flag;
  endproperty
  a_lp_flag: assert property (p_lp_flag)
    else $error("low power kept tx full");
  property p_lock_tx;
    tx_enable |=> $stable({tx_stop2, ir_output_sel});
  endproperty
  a_lock_tx: assert property (p_lock_tx)
    else $error("tx fields changed while locked");
  property p_lock_all;
    tx_enable || rx_enable |=>
      $stable({parity_even, parity_add, base_clock_sel, sample_count_sel});
  endproperty
  a_lock_all: assert property (p_lock_all)
    else $error("shared fields changed while locked");
  property p_lock_rx;
    rx_enable |=> $stable({noise_time_sel, rx_stop2});
  endproperty
  a_lock_rx: assert property (p_lock_rx)
    else $error("rx fields changed while locked");
  property p_status_rd;
    rd_s |-> prdata[31:8] == 24'h000000 && !prdata[4];
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status unused bits set");
  property p_gate_on;
    wr_p && pwdata[0] && !lp |-> ##2 port_clock_on && !port_halt;
  endproperty
  a_gate_on: assert property (p_gate_on)
    else $error("port clock not supplied");
  property p_gate_off;
    wr_p && !pwdata[0] |-> ##2 !port_clock_on && port_halt;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("port clock not stopped");
endmodule

bind serial_status_block serial_status_chk chk_u (.clock(clock),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .stop_mode(stop_mode), .idle_lowpower_mode(idle_lowpower_mode),
  .sleep_lowpower_mode(sleep_lowpower_mode), .tx_done_irq(tx_done_irq),
  .port_clock_on(port_clock_on), .port_halt(port_halt),
  .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_stop2(tx_stop2),
  .parity_even(parity_even), .parity_add(parity_add),
  .ir_output_sel(ir_output_sel), .base_clock_sel(base_clock_sel),
  .sample_count_sel(sample_count_sel), .noise_time_sel(noise_time_sel),
  .rx_stop2(rx_stop2), .tx_byte(tx_byte), .tx_full_flag(tx_full_flag));

// ==== tb/serial_engine_model.sv ====
// shift engine stand-in driving busy, data and event lines
module serial_engine_model
(
  input wire logic clock,
  input wire logic tx_enable,
  input wire logic tx_full_flag,
  output logic engine_rx_busy,
  output logic engine_tx_busy,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic parity_error_pulse,
  output logic framing_error_pulse,
  output logic tx_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {engine_rx_busy, engine_tx_busy, rx_byte_valid} = 3'h0;
    {parity_error_pulse, framing_error_pulse, tx_done_irq} = 3'h0;
    rx_byte = 8'hFF;
  end
  // ==========================================
  // transmit: full buffer starts a frame, done pulse at its end
  always
  begin
    @(posedge clock);
    if (tx_enable && tx_full_flag)
    begin
      engine_tx_busy <= 1'b1;
      repeat (20) @(posedge clock);
      engine_tx_busy <= 1'b0;
      tx_done_irq <= 1'b1;
      @(posedge clock);
      tx_done_irq <= 1'b0;
      @(posedge clock);
    end
  end
  // ==========================================
  // receive one frame, data line inverted once released
  task automatic receive(input logic [7:0] b, input logic par_bad,
    input logic frm_bad);
    engine_rx_busy <= 1'b1;
    repeat (6) @(posedge clock);
    engine_rx_busy <= 1'b0;
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    parity_error_pulse <= par_bad;
    framing_error_pulse <= frm_bad;
    @(posedge clock);
    {rx_byte_valid, parity_error_pulse, framing_error_pulse} <= 3'h0;
    rx_byte <= ~b;
  endtask
endmodule

// ==== tb/serial_status_block_bench.sv ====
// register level test of the serial status block
module serial_status_block_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, e, port_clock_on, port_halt, tx_enable, rx_enable;
  logic tx_stop2, parity_even, parity_add, ir_output_sel, base_clock_sel;
  logic [2:0] sample_count_sel, lp = 3'h0;
  logic [1:0] noise_time_sel;
  logic [7:0] baud_divisor, tx_byte, rx_byte;
  logic rx_stop2, tx_full_flag, engine_rx_busy, engine_tx_busy;
  logic rx_byte_valid, parity_error_pulse, framing_error_pulse, tx_done_irq;
  int num_errors = 0, n_compared = 0;
  wire [4:0] fa = {tx_stop2, parity_even, parity_add, ir_output_sel,
    base_clock_sel};
  wire [5:0] fb = {sample_count_sel, noise_time_sel, rx_stop2};
  always #25 clock = ~clock;
  serial_status_block dut_u (.clock(clock), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(lp[0]), .idle_lowpower_mode(lp[1]),
    .sleep_lowpower_mode(lp[2]), .engine_rx_busy(engine_rx_busy),
    .engine_tx_busy(engine_tx_busy), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .parity_error_pulse(parity_error_pulse),
    .framing_error_pulse(framing_error_pulse), .tx_done_irq(tx_done_irq),
    .port_clock_on(port_clock_on), .port_halt(port_halt),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_stop2(tx_stop2),
    .parity_even(parity_even), .parity_add(parity_add),
    .ir_output_sel(ir_output_sel), .base_clock_sel(base_clock_sel),
    .sample_count_sel(sample_count_sel), .noise_time_sel(noise_time_sel),
    .rx_stop2(rx_stop2), .baud_divisor(baud_divisor), .tx_byte(tx_byte),
    .tx_full_flag(tx_full_flag));
  serial_engine_model eng_u (.clock(clock), .tx_enable(tx_enable),
    .tx_full_flag(tx_full_flag), .engine_rx_busy(engine_rx_busy),
    .engine_tx_busy(engine_tx_busy), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .parity_error_pulse(parity_error_pulse),
    .framing_error_pulse(framing_error_pulse), .tx_done_irq(tx_done_irq));
  // ==========================================
  // tasks
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, x);
    n_compared++;
    if (s !== x)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      num_errors++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h00000000);
    check(nm, q, x);
  endtask
  // ==========================================
  // sequence
  initial
  begin
    int n;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check("clock_on", port_clock_on, 32'h0);
    wr(8'h68, 32'hFF);
    check("tx_en_gated", tx_enable, 32'h0);
    wr(8'h7C, 32'h1);
    @(posedge clock);
    check("clock_on", {port_clock_on, port_halt}, 32'h2);
    rd("gate_rd", 8'h7C, 32'h1);
    wr(8'h70, 32'hC3);
    rd("baud_rd", 8'h70, 32'hC3);
    check("baud_out", baud_divisor, 32'hC3);
    rd("unmapped", 8'h00, 32'h0);
    check("slverr", e, 32'h1);
    wr(8'h74, 32'hFF);
    rd("status_ro", 8'h74, 32'h0);
    wr(8'h68, 32'h3E);
    wr(8'h6C, 32'h3F);
    check("cfg_b", fb, 32'h3F);
    wr(8'h68, 32'hBE);
    wr(8'h68, 32'h80);
    check("cfg_a", fa, 32'h1F);
    wr(8'h6C, 32'h00);
    check("cfg_b", fb, 32'h38);
    wr(8'h68, 32'h40);
    wr(8'h68, 32'h40);
    check("cfg_a", fa, 32'h0D);
    rd("cfg_a_rd", 8'h68, 32'h5A);
    wr(8'h6C, 32'h3F);
    check("cfg_b", fb, 32'h38);
    rd("cfg_b_rd", 8'h6C, 32'h38);
    fork
      eng_u.receive(8'h3C, 1'b0, 1'b0);
      begin
        repeat (2) @(posedge clock);
        rd("rx_busy", 8'h74, 32'h08);
      end
    join
    rd("rx_full", 8'h74, 32'h04);
    rd("rx_data", 8'h78, 32'h3C);
    rd("rx_empty", 8'h74, 32'h00);
    eng_u.receive(8'h11, 1'b1, 1'b1);
    eng_u.receive(8'h22, 1'b0, 1'b0);
    rd("errors", 8'h74, 32'hE4);
    rd("err_clear", 8'h74, 32'h04);
    rd("overrun_keep", 8'h78, 32'h11);
    wr(8'h68, 32'hA4);
    check("cfg_a", fa, 32'h1F);
    wr(8'h78, 32'hA5);
    check("tx_byte", {tx_byte, tx_full_flag}, 32'h14B);
    repeat (2) @(posedge clock);
    rd("tx_busy", 8'h74, 32'h03);
    wr(8'h68, 32'h00);
    wr(8'h68, 32'h04);
    check("cfg_a", fa, 32'h1F);
    n = 0;
    while (tx_full_flag !== 1'b0 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    check("tx_full", tx_full_flag, 32'h0);
    repeat (2) @(posedge clock);
    rd("tx_idle", 8'h74, 32'h00);
    wr(8'h68, 32'h24);
    check("cfg_a", fa, 32'h12);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h68, (i == 0) ? 32'hE4 : 32'h64);
      eng_u.receive(8'h5A, 1'b0, 1'b0);
      rd("rx_data", 8'h78, 32'h5A);
      eng_u.receive(8'h5A, 1'b0, 1'b1);
      if (i > 0)
        wr(8'h78, 32'hA5);
      lp <= 3'(1 << i);
      repeat (4) @(posedge clock);
      check("lp_en", {tx_enable, rx_enable, fa}, 32'h12);
      lp <= 3'h0;
      repeat (2) @(posedge clock);
      rd("lp_status", 8'h74, 32'h00);
    end
    wr(8'h7C, 32'h0);
    @(posedge clock);
    check("clock_off", {port_clock_on, port_halt}, 32'h1);
    report_and_stop();
  end
endmodule
